// ==== src/seci_pkg.sv ====
package seci_pkg;

    // opcodes, most significant bit first on the wire
    localparam logic [7:0] SECI_READ_OPCODE = 8'h03;
    localparam logic [7:0] SECI_WRITE_OPCODE = 8'h02;
    localparam logic [7:0] SECI_LATCH_CLEAR_OPCODE = 8'h04;
    localparam logic [7:0] SECI_LATCH_SET_OPCODE = 8'h06;
    localparam logic [7:0] SECI_STATUS_READ_OPCODE = 8'h05;
    localparam logic [7:0] SECI_STATUS_WRITE_OPCODE = 8'h01;

    // array geometry
    localparam int SECI_ADDR_W = 12;
    localparam int SECI_PAGE_W = 5;
    localparam int SECI_PAGE_BYTES = 32;
    localparam int SECI_MEM_BYTES = 4096;

    // bit counter end values
    localparam logic [4:0] SECI_BYTE_LAST = 5'h07;
    localparam logic [4:0] SECI_ADDR_LAST = 5'h0F;
    localparam logic [2:0] SECI_OUT_LAST = 3'h7;
    localparam logic [4:0] SECI_CNT_ZERO = 5'h00;

    // block protect codes
    localparam logic [1:0] SECI_BP_NONE = 2'h0;
    localparam logic [1:0] SECI_BP_QUARTER = 2'h1;
    localparam logic [1:0] SECI_BP_HALF = 2'h2;
    localparam logic [1:0] SECI_TOP_QUARTER = 2'h3;

    // internal write cycle time
    localparam int SECI_CLK_PERIOD_NS = 40;
    localparam int SECI_WRITE_TIME_NS = 5000000;
    localparam int SECI_WRITE_CYCLES = SECI_WRITE_TIME_NS / SECI_CLK_PERIOD_NS;
    localparam int SECI_TIMER_W = 17;

    // synchronised pin bundle
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } seci_pins_type;

    // idle pin levels: deselected, clock low, hold and protect released
    localparam seci_pins_type SECI_PINS_IDLE = 5'h13;

    // status byte layout
    typedef struct packed {
        logic protect_pin_enable_bit;
        logic [2:0] spare;
        logic block_protect_high_bit;
        logic block_protect_low_bit;
        logic write_enable_latch_flag;
        logic write_busy_flag;
    } seci_status_type;

    // frame phases, gray coded along opcode -> address -> data in
    typedef enum logic [2:0] {
        SECI_IDLE = 3'h0,
        SECI_OPCODE = 3'h1,
        SECI_ADDR = 3'h3,
        SECI_DATA_IN = 3'h2,
        SECI_DATA_OUT = 3'h6,
        SECI_STAT_OUT = 3'h7,
        SECI_STAT_IN = 3'h5,
        SECI_LATCH = 3'h4
    } seci_state_type;

endpackage

// ==== src/seci_core.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R1: chip select low selects; high means standby
// R2: started programming cycle always finishes first
// R3: serial output floats while deselected
// R4: no command before chip select first seen low
// R5: sample on clock rise, update after fall
// R6: protect pin plus enable bit blocks status writes
// R7: protect pin fall never disturbs running write
// R8: enable bit clear makes protect pin ignored
// R9: hold pauses now, or at next fall
// R10: paused ignores clock and input; output floats
// R11: resume at exact bit when hold released
// R12: master keeps select low, hold high otherwise
// R13: eight bit opcode first, msb first always
// R14: first bit on first rise after select
// R15: read opcode, sixteen bit address, then data
// R16: read pointer increments, wraps to zero
// R17: latch set only if select rises after opcode
// R18: write opcode, address, up to page bytes
// R19: write address wraps inside the page
// R20: commit only on select rise after byte end
// R21: status readable, array refused while busy
// R22: decode latch clear, status read, status write
// R23: busy in bit zero, latch in bit one
// R24: block protect selects refused array range
// R25: latch cleared at reset and after success
// R26: output driven only while shifting data out
module seci_core
    import seci_pkg::*;
#(
    parameter int WRITE_CYCLES = SECI_WRITE_CYCLES
)
(
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_in_i,
    input wire logic hold_n_i,
    input wire logic write_protect_n_i,
    output logic serial_out_o,
    output logic serial_out_en_n_o,
    // state
    output logic standby_o,
    output logic write_busy_o
);

    localparam logic [SECI_TIMER_W-1:0] TIMER_LAST = SECI_TIMER_W'(WRITE_CYCLES - 1);

    seci_pins_type raw, s1_reg, s2_reg, s3_reg, pin_reg, pin_prev_reg;
    logic sck_rise, sck_fall, cs_fall, cs_rise, paused_reg, active;
    seci_state_type state_reg;
    logic [4:0] cnt_reg;
    logic [15:0] shift_reg;
    logic [7:0] in_byte;
    logic [7:0] op_reg;
    logic [SECI_ADDR_W-1:0] addr_reg;
    logic [SECI_ADDR_W-1:0] addr_inc, addr_in;
    logic byte_done_reg;
    logic [7:0] out_reg;
    logic [2:0] out_cnt_reg;
    logic out_live_reg;
    logic [7:0] page_buf [SECI_PAGE_BYTES];
    logic [SECI_PAGE_BYTES-1:0] page_valid_reg;
    seci_status_type stat_data_reg;
    logic arr_go_reg, st_go_reg, set_go_reg, clr_go_reg, busy_reg, kind_array_reg;
    logic [SECI_TIMER_W-1:0] timer_reg;
    logic commit, wel_reg, protect_pin_enable_bit_reg;
    logic [1:0] bp_reg;
    seci_status_type status_now;
    logic [7:0] mem [SECI_MEM_BYTES];
    logic so_reg, so_en_n_reg, standby_reg;

    // true when the addressed page lies in the protected range
    function automatic logic range_locked(input logic [1:0] bp, input logic [1:0] top);
        case (bp)
            SECI_BP_NONE: range_locked = 1'b0;
            SECI_BP_QUARTER: range_locked = (top == SECI_TOP_QUARTER);
            SECI_BP_HALF: range_locked = top[1];
            default: range_locked = 1'b1;
        endcase
    endfunction

    assign raw = '{chip_select_n_i, serial_clock_i, serial_in_i, hold_n_i, write_protect_n_i};

    // three-stage synchronisers; a level is taken once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < $bits(seci_pins_type); g++)
        begin : g_sync
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    s1_reg[g] <= SECI_PINS_IDLE[g];
                    s2_reg[g] <= SECI_PINS_IDLE[g];
                    s3_reg[g] <= SECI_PINS_IDLE[g];
                    pin_reg[g] <= SECI_PINS_IDLE[g];
                    pin_prev_reg[g] <= SECI_PINS_IDLE[g];
                end
                else
                begin
                    s1_reg[g] <= raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g])
                        pin_reg[g] <= s3_reg[g];
                    pin_prev_reg[g] <= pin_reg[g];
                end
            end
        end
    endgenerate

    // edge events of the filtered levels
    assign sck_rise = pin_reg.sck & ~pin_prev_reg.sck;
    assign sck_fall = ~pin_reg.sck & pin_prev_reg.sck;
    assign cs_fall = ~pin_reg.cs_n & pin_prev_reg.cs_n;
    assign cs_rise = pin_reg.cs_n & ~pin_prev_reg.cs_n;
    // a clock edge counts only when selected, hold released and not paused
    assign active = (state_reg != SECI_IDLE) & ~pin_reg.cs_n & pin_reg.hold_n & ~paused_reg; // see R10
    assign in_byte = {shift_reg[6:0], pin_reg.si}; // see R13
    assign addr_in = {shift_reg[SECI_ADDR_W-2:0], pin_reg.si}; // top four address bits dropped, see R15
    assign addr_inc = addr_reg + 12'h001; // natural wrap past the top, see R16
    assign status_now = '{protect_pin_enable_bit_reg, 3'h0, bp_reg[1], bp_reg[0], wel_reg, busy_reg}; // see R23
    assign commit = busy_reg & (timer_reg == TIMER_LAST);

    // pause follows hold only while the clock is low and clears at once on deselect; a hold that falls
    // with the clock high suppresses the next fall and pauses after it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            paused_reg <= 1'b0;
        else if (pin_reg.cs_n)
            paused_reg <= 1'b0;
        else if (~pin_reg.sck)
            paused_reg <= ~pin_reg.hold_n; // see R9, see R11
    end

    // frame sequencer: opcode, address, data; shifting on rising clock
    always_ff @(posedge clk_i)
    begin
        arr_go_reg <= 1'b0;
        st_go_reg <= 1'b0;
        set_go_reg <= 1'b0;
        clr_go_reg <= 1'b0;
        if (rst_i)
        begin
            state_reg <= SECI_IDLE;
            cnt_reg <= SECI_CNT_ZERO;
            shift_reg <= 16'h0000;
            op_reg <= 8'h00;
            addr_reg <= 12'h000;
            byte_done_reg <= 1'b0;
            out_reg <= 8'h00;
            out_cnt_reg <= 3'h0;
            out_live_reg <= 1'b0;
            page_valid_reg <= '0;
            stat_data_reg <= 8'h00;
            so_reg <= 1'b0;
        end
        else if (cs_rise)
        begin
            // commits are requested here; the write block checks the gates
            case (state_reg)
                SECI_LATCH:
                begin
                    set_go_reg <= (op_reg == SECI_LATCH_SET_OPCODE); // see R17
                    clr_go_reg <= (op_reg == SECI_LATCH_CLEAR_OPCODE);
                end
                SECI_DATA_IN: arr_go_reg <= byte_done_reg; // see R20
                SECI_STAT_IN: st_go_reg <= byte_done_reg;
                default: ;
            endcase
            state_reg <= SECI_IDLE; // see R1, see R16
            out_live_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            // reset holds cs_n high, so only a real low after power-up opens a frame
            state_reg <= SECI_OPCODE; // see R4, see R14
            cnt_reg <= SECI_CNT_ZERO;
            byte_done_reg <= 1'b0;
            out_live_reg <= 1'b0;
        end
        else if (active & sck_rise)
        begin
            shift_reg <= {shift_reg[14:0], pin_reg.si}; // see R5
            cnt_reg <= cnt_reg + 5'h01;
            case (state_reg)
                SECI_OPCODE:
                begin
                    if (cnt_reg == SECI_BYTE_LAST)
                    begin
                        op_reg <= in_byte;
                        cnt_reg <= SECI_CNT_ZERO;
                        case (in_byte) // see R22
                            SECI_READ_OPCODE: state_reg <= busy_reg ? SECI_LATCH : SECI_ADDR; // see R21
                            SECI_WRITE_OPCODE: state_reg <= busy_reg ? SECI_LATCH : SECI_ADDR;
                            SECI_STATUS_READ_OPCODE:
                            begin
                                state_reg <= SECI_STAT_OUT;
                                out_reg <= status_now;
                                out_cnt_reg <= 3'h0;
                            end
                            SECI_STATUS_WRITE_OPCODE: state_reg <= busy_reg ? SECI_LATCH : SECI_STAT_IN;
                            default: state_reg <= SECI_LATCH;
                        endcase
                    end
                end
                SECI_ADDR:
                begin
                    if (cnt_reg == SECI_ADDR_LAST)
                    begin
                        addr_reg <= addr_in;
                        cnt_reg <= SECI_CNT_ZERO;
                        if (op_reg == SECI_READ_OPCODE)
                        begin
                            state_reg <= SECI_DATA_OUT;
                            out_reg <= mem[addr_in];
                            out_cnt_reg <= 3'h0;
                        end
                        else
                        begin
                            state_reg <= SECI_DATA_IN; // see R18
                            page_valid_reg <= '0;
                            byte_done_reg <= 1'b0;
                        end
                    end
                end
                SECI_DATA_IN:
                begin
                    byte_done_reg <= (cnt_reg == SECI_BYTE_LAST);
                    if (cnt_reg == SECI_BYTE_LAST)
                    begin
                        cnt_reg <= SECI_CNT_ZERO;
                        page_buf[addr_reg[SECI_PAGE_W-1:0]] <= in_byte;
                        page_valid_reg[addr_reg[SECI_PAGE_W-1:0]] <= 1'b1;
                        // low five bits roll over, page bits stay put
                        addr_reg[SECI_PAGE_W-1:0] <= addr_reg[SECI_PAGE_W-1:0] + 5'h01; // see R19
                    end
                end
                SECI_STAT_IN:
                begin
                    // only a single status byte is accepted
                    if (byte_done_reg)
                    begin
                        state_reg <= SECI_LATCH;
                        byte_done_reg <= 1'b0;
                    end
                    else if (cnt_reg == SECI_BYTE_LAST)
                    begin
                        stat_data_reg <= in_byte;
                        byte_done_reg <= 1'b1;
                    end
                end
                SECI_LATCH:
                begin
                    // any clock after the opcode cancels the latch action
                    op_reg <= 8'h00; // see R17
                end
                default: ;
            endcase
        end
        else if (active & sck_fall & ((state_reg == SECI_DATA_OUT) | (state_reg == SECI_STAT_OUT)))
        begin
            so_reg <= out_reg[7]; // see R5
            out_live_reg <= 1'b1;
            out_reg <= {out_reg[6:0], 1'b0};
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (out_cnt_reg == SECI_OUT_LAST)
            begin
                if (state_reg == SECI_DATA_OUT)
                begin
                    addr_reg <= addr_inc; // see R16
                    out_reg <= mem[addr_inc];
                end
                else
                begin
                    out_reg <= status_now;
                end
            end
        end
    end

    // internal write cycle, latch and nonvolatile status bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_reg <= 1'b0;
            kind_array_reg <= 1'b0;
            timer_reg <= '0;
            wel_reg <= 1'b0; // see R25
            protect_pin_enable_bit_reg <= 1'b0;
            bp_reg <= SECI_BP_NONE;
        end
        else if (busy_reg)
        begin
            // runs to the end regardless of select or protect pin
            timer_reg <= timer_reg + SECI_TIMER_W'(1); // see R2, see R7
            if (commit)
            begin
                busy_reg <= 1'b0;
                wel_reg <= 1'b0; // see R21, see R25
                if (~kind_array_reg)
                begin
                    protect_pin_enable_bit_reg <= stat_data_reg.protect_pin_enable_bit;
                    bp_reg <= {stat_data_reg.block_protect_high_bit, stat_data_reg.block_protect_low_bit}; // see R24
                end
            end
        end
        else if (set_go_reg)
            wel_reg <= 1'b1; // see R17
        else if (clr_go_reg)
            wel_reg <= 1'b0; // see R25
        else if (arr_go_reg & wel_reg & ~range_locked(bp_reg, addr_reg[SECI_ADDR_W-1:SECI_ADDR_W-2])) // see R24
        begin
            busy_reg <= 1'b1;
            kind_array_reg <= 1'b1;
            timer_reg <= '0;
        end
        else if (st_go_reg & wel_reg & ~(protect_pin_enable_bit_reg & ~pin_reg.wp_n)) // see R6, see R8
        begin
            busy_reg <= 1'b1;
            kind_array_reg <= 1'b0;
            timer_reg <= '0;
        end
    end

    // array storage; the page buffer lands at the end of the cycle
    always_ff @(posedge clk_i)
    begin
        if (commit & kind_array_reg)
        begin
            for (int i = 0; i < SECI_PAGE_BYTES; i++)
            begin
                if (page_valid_reg[i])
                    mem[{addr_reg[SECI_ADDR_W-1:SECI_PAGE_W], SECI_PAGE_W'(i)}] <= page_buf[i];
            end
        end
    end

    // output enable: low only while shifting out; any hold floats it at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            so_en_n_reg <= 1'b1;
            standby_reg <= 1'b1;
        end
        else
        begin
            so_en_n_reg <= ~(active & out_live_reg & ~cs_rise); // see R3, see R10, see R26
            standby_reg <= pin_reg.cs_n & ~busy_reg; // see R1, see R2
        end
    end

    assign serial_out_o = so_reg;
    assign serial_out_en_n_o = so_en_n_reg;
    assign standby_o = standby_reg;
    assign write_busy_o = busy_reg;

endmodule // seci_core

// ==== verification/seci_core_properties.sv ====
`timescale 1ns/1ps
module seci_core_properties
    import seci_pkg::*;
#(
    parameter int WRITE_CYCLES = SECI_WRITE_CYCLES
)
(
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_in_i,
    input wire logic hold_n_i,
    input wire logic write_protect_n_i,
    input wire logic serial_out_o,
    input wire logic serial_out_en_n_o,
    // state
    input wire logic standby_o,
    input wire logic write_busy_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // clocks spent busy; one clock of slack covers the pin filter
    int busy_len_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !write_busy_o)
            busy_len_reg <= 0;
        else
            busy_len_reg <= busy_len_reg + 1;
    end

    property p_idle_float;
        chip_select_n_i [*6] |-> serial_out_en_n_o;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("output driven while deselected");
    property p_hold_float;
        !hold_n_i [*6] |-> serial_out_en_n_o;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("output driven while paused");
    property p_standby;
        chip_select_n_i [*6] ##0 (!write_busy_o && !$past(write_busy_o)) |-> standby_o;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby while deselected and idle");
    property p_busy_len;
        $fell(write_busy_o) |-> busy_len_reg >= WRITE_CYCLES - 1 && busy_len_reg <= WRITE_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_busy_hold;
        $rose(write_busy_o) |-> write_busy_o [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");
    property p_commit;
        $rose(write_busy_o) |-> $past(chip_select_n_i, 2);
    endproperty
    a_commit: assert property (p_commit) else $error("write cycle without deselect");
    property p_out_fall;
        !serial_out_en_n_o && !$past(serial_out_en_n_o) && $changed(serial_out_o) |-> !$past(serial_clock_i, 4);
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("output moved away from a clock fall");
    property p_sel_drive;
        !serial_out_en_n_o |-> !$past(chip_select_n_i, 6);
    endproperty
    a_sel_drive: assert property (p_sel_drive) else $error("output driven without selection");

    // main scenarios reached
    c_write: cover property ($rose(write_busy_o));
    c_drive: cover property ($fell(serial_out_en_n_o));
    c_pause: cover property ($fell(hold_n_i) && !chip_select_n_i);
endmodule // seci_core_properties

bind seci_core seci_core_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (
    .clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(chip_select_n_i), .serial_clock_i(serial_clock_i),
    .serial_in_i(serial_in_i), .hold_n_i(hold_n_i), .write_protect_n_i(write_protect_n_i),
    .serial_out_o(serial_out_o), .serial_out_en_n_o(serial_out_en_n_o), .standby_o(standby_o),
    .write_busy_o(write_busy_o)
);

// ==== verification/seci_spi_master.sv ====
`timescale 1ns/1ps
module seci_spi_master
(
    // system
    input wire logic clk_i,
    // bus pins
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic hold_n_o
);
    // deselected, clock parked low, hold released
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end

    // one bit: data set in the low half, taken on the rise; 8 clocks a bit
    task automatic send_bit(input logic b);
        @(posedge clk_i) si_o <= b;
        repeat (3) @(posedge clk_i);
        sck_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b0;
    endtask

    task automatic send8(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            send_bit(v[i]);
    endtask

    // clock stays low around select edges so no stray edge is taken
    task automatic start;
        @(posedge clk_i) cs_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // deselect only on whole bits; data line toggles since nobody owns it now
    task automatic stop;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        repeat (12) @(posedge clk_i);
    endtask

    // pause with clock low; clock and data wiggle to prove they are ignored
    task automatic pause(input int n);
        repeat (6) @(posedge clk_i);
        hold_n_o <= 1'b0;
        repeat (n)
        begin
            repeat (4) @(posedge clk_i);
            sck_o <= ~sck_o;
            si_o <= ~si_o;
        end
        repeat (4) @(posedge clk_i);
        hold_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // seci_spi_master

// ==== verification/spi_eeprom_command_interface_tb.sv ====
`timescale 1ns/1ps
module spi_eeprom_command_interface_tb
    import seci_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, hold_n, so, so_en_n, standby, busy;
    int error_cnt = 0;
    int n_checks = 0;
    logic [7:0] exp_q[$];
    logic [7:0] wq[$];
    logic [7:0] d[3];
    logic [7:0] rx;
    int rx_n = 0;

    always #20 clk_i = ~clk_i;

    seci_spi_master m_u (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n));
    seci_core #(.WRITE_CYCLES(400)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n), .serial_clock_i(sck), .serial_in_i(si),
        .hold_n_i(hold_n), .write_protect_n_i(wp_n), .serial_out_o(so), .serial_out_en_n_o(so_en_n),
        .standby_o(standby), .write_busy_o(busy));

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic end_of_test;
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // output bit held since the previous fall is taken at each fall
    always @(negedge sck)
    begin
        if (so_en_n === 1'b0)
        begin
            rx = {rx[6:0], so};
            rx_n++;
            if (rx_n == 8)
            begin
                rx_n = 0;
                if (exp_q.size() == 0)
                    chk("unexpected byte", 8'h00, 8'hFF);
                else
                    chk("read byte", exp_q.pop_front(), rx);
            end
        end
    end
    always @(posedge cs_n) rx_n = 0;

    task automatic addr(input logic [15:0] a);
        m_u.send8(a[15:8]);
        m_u.send8(a[7:0]);
    endtask

    task automatic cmd(input logic [7:0] op);
        m_u.start();
        m_u.send8(op);
        m_u.stop();
    endtask

    task automatic sr(input logic [7:0] e);
        exp_q.push_back(e);
        m_u.start();
        m_u.send8(SECI_STATUS_READ_OPCODE);
        m_u.send8(8'($urandom));
        m_u.stop();
    endtask

    task automatic rd(input logic [15:0] a, input int n);
        m_u.start();
        m_u.send8(SECI_READ_OPCODE);
        addr(a);
        repeat (8 * n) m_u.send_bit(1'($urandom));
        m_u.stop();
    endtask

    // opcode, optional address, then the bytes queued in wq
    task automatic wr(input logic [7:0] op, input logic [15:0] a, input logic has_addr);
        m_u.start();
        m_u.send8(op);
        if (has_addr)
            addr(a);
        foreach (wq[i]) m_u.send8(wq[i]);
        m_u.stop();
    endtask

    // called with select high, so standby follows busy
    task automatic busy_is(input logic e);
        chk("write busy", {7'h00, e}, {7'h00, busy});
        chk("standby", {7'h00, ~e}, {7'h00, standby});
    endtask

    task automatic wait_idle;
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 600)
        begin
            @(posedge clk_i);
            i++;
        end
        @(posedge clk_i); // standby trails busy by one clock
        busy_is(1'b0);
        if (busy !== 1'b0)
            end_of_test();
    endtask

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk_i);
        chk("run time", 8'h00, 8'h01);
        end_of_test();
    end

    initial
    begin
        void'($urandom(41000));
        foreach (d[i]) d[i] = 8'($urandom);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        // latch opcodes seen through the status byte
        cmd(SECI_LATCH_SET_OPCODE);
        sr(8'h02);
        cmd(SECI_LATCH_CLEAR_OPCODE);
        sr(8'h00);
        // latch set that runs straight into a write sets nothing
        m_u.start();
        m_u.send8(SECI_LATCH_SET_OPCODE);
        wq = '{d[0]};
        wr(SECI_WRITE_OPCODE, 16'h0000, 1'b1);
        busy_is(1'b0);
        // page write crossing the page end, busy status, array read refused
        cmd(SECI_LATCH_SET_OPCODE);
        wq = '{d[0], d[1]};
        wr(SECI_WRITE_OPCODE, 16'hAFFF, 1'b1);
        busy_is(1'b1);
        sr(8'h03);
        rd(16'h0FFF, 1);
        wait_idle();
        sr(8'h00);
        cmd(SECI_LATCH_SET_OPCODE);
        wq = '{d[2]};
        wr(SECI_WRITE_OPCODE, 16'h0000, 1'b1);
        wait_idle();
        // read wraps at the array end; top address bits ignored
        exp_q.push_back(d[0]);
        exp_q.push_back(d[2]);
        rd(16'hFFFF, 2);
        exp_q.push_back(d[1]);
        rd(16'h0FE0, 1);
        // paused read resumes at the same bit
        exp_q.push_back(d[0]);
        exp_q.push_back(d[2]);
        m_u.start();
        m_u.send8(SECI_READ_OPCODE);
        addr(16'h0FFF);
        repeat (4) m_u.send_bit(1'b0);
        m_u.pause(4);
        repeat (12) m_u.send_bit(1'b1);
        m_u.stop();
        // deselect mid-byte abandons the write, latch stays set
        cmd(SECI_LATCH_SET_OPCODE);
        m_u.start();
        m_u.send8(SECI_WRITE_OPCODE);
        addr(16'h0000);
        repeat (5) m_u.send_bit(1'b1);
        m_u.stop();
        busy_is(1'b0);
        sr(8'h02);
        // protect enable plus whole-array block protect
        wq = '{8'h8C};
        wr(SECI_STATUS_WRITE_OPCODE, 16'h0000, 1'b0);
        wait_idle();
        sr(8'h8C);
        cmd(SECI_LATCH_SET_OPCODE);
        wq = '{d[1]};
        wr(SECI_WRITE_OPCODE, 16'h0000, 1'b1);
        busy_is(1'b0);
        @(posedge clk_i) wp_n <= 1'b0;
        wq = '{8'h00};
        wr(SECI_STATUS_WRITE_OPCODE, 16'h0000, 1'b0);
        busy_is(1'b0);
        sr(8'h8E);
        @(posedge clk_i) wp_n <= 1'b1;
        wq = '{8'h04};
        wr(SECI_STATUS_WRITE_OPCODE, 16'h0000, 1'b0);
        busy_is(1'b1);
        @(posedge clk_i) wp_n <= 1'b0;
        wait_idle();
        sr(8'h04);
        // upper quarter protected: boundary addresses
        cmd(SECI_LATCH_SET_OPCODE);
        wq = '{d[1]};
        wr(SECI_WRITE_OPCODE, 16'h0C00, 1'b1);
        busy_is(1'b0);
        wr(SECI_WRITE_OPCODE, 16'h0BFF, 1'b1);
        busy_is(1'b1);
        wait_idle();
        exp_q.push_back(d[1]);
        rd(16'h0BFF, 1);
        // protect enable clear: pin low is ignored; then half array protected
        cmd(SECI_LATCH_SET_OPCODE);
        wq = '{8'h08};
        wr(SECI_STATUS_WRITE_OPCODE, 16'h0000, 1'b0);
        busy_is(1'b1);
        wait_idle();
        sr(8'h08);
        cmd(SECI_LATCH_SET_OPCODE);
        wq = '{d[2]};
        wr(SECI_WRITE_OPCODE, 16'h0800, 1'b1);
        busy_is(1'b0);
        wr(SECI_WRITE_OPCODE, 16'h07FF, 1'b1);
        busy_is(1'b1);
        wait_idle();
        exp_q.push_back(d[2]);
        rd(16'h07FF, 1);
        chk("bytes left", 8'h00, 8'(exp_q.size()));
        end_of_test();
    end
endmodule // spi_eeprom_command_interface_tb
